// File: rtl/ptp_global_index_trigger_status.v
`timescale 1ns/1ps
`include "ptp_regs_defines.vh"
module ptp_global_index_trigger_status (
  input  wire        CLK,
  input  wire        RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output wire        PREADY,
  output reg  [31:0] PRDATA,
  output wire        PSLVERR,
  input  wire        MSG_VALID,
  input  wire [3:0]  MSG_VERSION,
  input  wire [7:0]  MSG_DOMAIN,
  output wire        MSG_CAPTURE,
  output wire        MSG_FORWARD,
  output wire        MSG_DROP,
  input  wire [2:0]  TRIG_LATE,
  input  wire [2:0]  TRIG_DONE_EV,
  input  wire [2:0]  trig_irq_request_enable,
  input  wire [2:0]  TRIG_EN_CLEAR,
  output wire        WIN_ACCESS,
  output wire        pin_select_bit,
  output wire        stamp_unit_select_bit,
  output wire [1:0]  trig_unit_select_field,
  output wire [2:0]  TRIG_UNIT_ONEHOT,
  output wire [1:0]  STAMP_UNIT_ONEHOT,
  output wire [1:0]  PIN_ONEHOT,
  output wire        IRQ
);
  reg  [3:0]  version_q;
  reg  [7:0]  programmed_time_domain_q;
  reg         pin_sel_q;
  reg         stamp_sel_q;
  reg  [1:0]  trig_sel_q;
  reg  [2:0]  rsv_hi_q;
  reg  [2:0]  rsv_mid_q;
  reg         domain_check_q;
  reg  [`IRQ_WIDTH-1:0] irq_mask_q;
  wire [2:0]  err_flag;
  wire [2:0]  done_flag;
  wire [2:0]  err_irq_flag;
  wire [2:0]  done_irq_flag;
  wire        drop_irq_flag;
  wire [`IRQ_WIDTH-1:0] irq_status;
  wire        wr_en;
  wire        rd_en;
  wire        hit;
  wire [2:0]  err_set;
  wire [2:0]  done_set;
  wire [2:0]  done_clr;
  wire [2:0]  err_irq_clr;
  wire [2:0]  done_irq_clr;
  wire        drop_irq_clr;
  reg  [31:0] rdata_d;
  wire        drop_pulse;

  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign rd_en   = PSEL && PENABLE && !PWRITE;

  assign hit = (PADDR == `ADDR_DOMAIN_VERSION) || (PADDR == `ADDR_UNIT_INDEX) ||
               (PADDR == `ADDR_TRIG_STATUS) || (PADDR == `ADDR_IRQ_STATUS) ||
               (PADDR == `ADDR_IRQ_MASK) || (PADDR == `ADDR_PTP_CONFIG);

  // writable control registers
  always @(posedge CLK) begin
    if (RST) begin
      version_q                <= `VERSION_RESET;
      programmed_time_domain_q <= `DOMAIN_RESET;
      pin_sel_q                <= 1'b0;
      stamp_sel_q              <= 1'b0;
      trig_sel_q               <= 2'h0;
      rsv_hi_q                 <= 3'h0;
      rsv_mid_q                <= 3'h0;
      domain_check_q           <= 1'b0;
      irq_mask_q               <= {`IRQ_WIDTH{1'b0}};
    end else if (wr_en) begin
      case (PADDR)
        `ADDR_DOMAIN_VERSION: begin
          version_q                <= PWDATA[`VERSION_MSB:`VERSION_LSB];
          programmed_time_domain_q <= PWDATA[`DOMAIN_MSB:`DOMAIN_LSB];
        end
        `ADDR_UNIT_INDEX: begin
          pin_sel_q   <= PWDATA[`PIN_SEL_BIT];
          stamp_sel_q <= PWDATA[`STAMP_SEL_BIT];
          trig_sel_q  <= PWDATA[`TRIG_SEL_MSB:`TRIG_SEL_LSB];
          rsv_hi_q    <= PWDATA[`RSV_HI_MSB:`RSV_HI_LSB];
          rsv_mid_q   <= PWDATA[`RSV_MID_MSB:`RSV_MID_LSB];
        end
        `ADDR_PTP_CONFIG: begin
          domain_check_q <= PWDATA[`DOMAIN_CHECK_BIT];
        end
        `ADDR_IRQ_MASK: begin
          irq_mask_q <= PWDATA[`IRQ_WIDTH-1:0];
        end
        default: begin
          irq_mask_q <= irq_mask_q;
        end
      endcase
    end
  end

  // unit selection toward the indexed window
  assign WIN_ACCESS = PSEL && (PADDR >= `ADDR_WINDOW_LO) &&
                      (PADDR <= `ADDR_WINDOW_HI);
  assign pin_select_bit         = pin_sel_q;
  assign stamp_unit_select_bit  = stamp_sel_q;
  assign trig_unit_select_field = trig_sel_q;
  assign PIN_ONEHOT        = {pin_sel_q, !pin_sel_q};
  assign STAMP_UNIT_ONEHOT = {stamp_sel_q, !stamp_sel_q};
  // code 11 selects no unit
  assign TRIG_UNIT_ONEHOT  = (trig_sel_q == `TRIG_SEL_RESERVED) ? 3'h0 :
                             (3'h1 << trig_sel_q);

  // trigger flags
  assign err_set  = TRIG_LATE & trig_irq_request_enable;
  assign done_set = TRIG_DONE_EV & trig_irq_request_enable;
  assign done_clr = (wr_en && PADDR == `ADDR_TRIG_STATUS) ?
                    PWDATA[`TRIG_DONE_MSB:`TRIG_DONE_LSB] : 3'h0;
  assign err_irq_clr  = (wr_en && PADDR == `ADDR_IRQ_STATUS) ?
                        PWDATA[`IRQ_ERR_MSB:`IRQ_ERR_LSB] : 3'h0;
  assign done_irq_clr = (wr_en && PADDR == `ADDR_IRQ_STATUS) ?
                        PWDATA[`IRQ_DONE_MSB:`IRQ_DONE_LSB] : 3'h0;
  assign drop_irq_clr = wr_en && (PADDR == `ADDR_IRQ_STATUS) && PWDATA[`IRQ_DROP_BIT];

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_trig
      trig_flag_cell u_err (
        .CLK    (CLK),
        .RST    (RST),
        .set_ev (err_set[i]),
        .clr_ev (TRIG_EN_CLEAR[i]),
        .flag_q (err_flag[i])
      );
      trig_flag_cell u_done (
        .CLK    (CLK),
        .RST    (RST),
        .set_ev (done_set[i]),
        .clr_ev (done_clr[i]),
        .flag_q (done_flag[i])
      );
      trig_flag_cell u_err_irq (
        .CLK    (CLK),
        .RST    (RST),
        .set_ev (err_set[i]),
        .clr_ev (err_irq_clr[i]),
        .flag_q (err_irq_flag[i])
      );
      trig_flag_cell u_done_irq (
        .CLK    (CLK),
        .RST    (RST),
        .set_ev (done_set[i]),
        .clr_ev (done_irq_clr[i]),
        .flag_q (done_irq_flag[i])
      );
    end
  endgenerate

  trig_flag_cell u_drop_irq (
    .CLK    (CLK),
    .RST    (RST),
    .set_ev (drop_pulse),
    .clr_ev (drop_irq_clr),
    .flag_q (drop_irq_flag)
  );

  ptp_msg_filter u_filter (
    .CLK          (CLK),
    .RST          (RST),
    .msg_valid    (MSG_VALID),
    .msg_version  (MSG_VERSION),
    .msg_domain   (MSG_DOMAIN),
    .prog_version (version_q),
    .prog_domain  (programmed_time_domain_q),
    .domain_check (domain_check_q),
    .capture_q    (MSG_CAPTURE),
    .forward_q    (MSG_FORWARD),
    .drop_q       (drop_pulse)
  );
  assign MSG_DROP = drop_pulse;

  assign irq_status = {drop_irq_flag, err_irq_flag, done_irq_flag};
  assign IRQ = |(irq_status & irq_mask_q);

  // read mux, reserved read-only bits zero
  always @* begin
    rdata_d = 32'h00000000;
    case (PADDR)
      `ADDR_DOMAIN_VERSION: begin
        rdata_d[`VERSION_MSB:`VERSION_LSB] = version_q;
        rdata_d[`DOMAIN_MSB:`DOMAIN_LSB]   = programmed_time_domain_q;
      end
      `ADDR_UNIT_INDEX: begin
        rdata_d[`RSV_HI_MSB:`RSV_HI_LSB]     = rsv_hi_q;
        rdata_d[`PIN_SEL_BIT]                = pin_sel_q;
        rdata_d[`RSV_MID_MSB:`RSV_MID_LSB]   = rsv_mid_q;
        rdata_d[`STAMP_SEL_BIT]              = stamp_sel_q;
        rdata_d[`TRIG_SEL_MSB:`TRIG_SEL_LSB] = trig_sel_q;
      end
      `ADDR_TRIG_STATUS: begin
        rdata_d[`TRIG_ERR_MSB:`TRIG_ERR_LSB]   = err_flag;
        rdata_d[`TRIG_DONE_MSB:`TRIG_DONE_LSB] = done_flag;
      end
      `ADDR_IRQ_STATUS: begin
        rdata_d[`IRQ_WIDTH-1:0] = irq_status;
      end
      `ADDR_IRQ_MASK: begin
        rdata_d[`IRQ_WIDTH-1:0] = irq_mask_q;
      end
      `ADDR_PTP_CONFIG: begin
        rdata_d[`DOMAIN_CHECK_BIT] = domain_check_q;
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  // read data captured in setup phase, stable in access phase
  always @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= hit ? rdata_d : 32'h00000000;
    end else if (rd_en) begin
      PRDATA <= PRDATA;
    end
  end
endmodule

// File: rtl/ptp_msg_filter.v
`timescale 1ns/1ps
`include "ptp_regs_defines.vh"
module ptp_msg_filter (
  input  wire       CLK,
  input  wire       RST,
  input  wire       msg_valid,
  input  wire [3:0] msg_version,
  input  wire [7:0] msg_domain,
  input  wire [3:0] prog_version,
  input  wire [7:0] prog_domain,
  input  wire       domain_check,
  output reg        capture_q,
  output reg        forward_q,
  output reg        drop_q
);
  wire ver_ok;
  wire dom_ok;
  wire accept;

  assign ver_ok = (msg_version == prog_version);
  assign dom_ok = !domain_check || (msg_domain == prog_domain);
  assign accept = ver_ok && dom_ok;

  always @(posedge CLK) begin
    if (RST) begin
      capture_q <= 1'b0;
      forward_q <= 1'b0;
      drop_q    <= 1'b0;
    end else begin
      capture_q <= msg_valid && accept;
      forward_q <= msg_valid && accept;
      drop_q    <= msg_valid && !accept;
    end
  end
endmodule

// File: rtl/trig_flag_cell.v
`timescale 1ns/1ps
module trig_flag_cell (
  input  wire CLK,
  input  wire RST,
  input  wire set_ev,
  input  wire clr_ev,
  output reg  flag_q
);
  // set wins over a simultaneous clear
  always @(posedge CLK) begin
    if (RST) begin
      flag_q <= 1'b0;
    end else if (set_ev) begin
      flag_q <= 1'b1;
    end else if (clr_ev) begin
      flag_q <= 1'b0;
    end
  end
endmodule

// File: shared/ptp_regs_defines.vh
`ifndef PTP_REGS_DEFINES_VH
`define PTP_REGS_DEFINES_VH

// register byte addresses
`define ADDR_DOMAIN_VERSION  12'h518
`define ADDR_UNIT_INDEX      12'h520
`define ADDR_TRIG_STATUS     12'h524
`define ADDR_IRQ_STATUS      12'h540
`define ADDR_IRQ_MASK        12'h544
`define ADDR_PTP_CONFIG      12'h548
`define ADDR_WINDOW_LO       12'h52C
`define ADDR_WINDOW_HI       12'h5B3

// domain and version register fields
`define VERSION_MSB          11
`define VERSION_LSB          8
`define VERSION_RESET        4'h2
`define DOMAIN_MSB           7
`define DOMAIN_LSB           0
`define DOMAIN_RESET         8'h00

// unit index register fields
`define PIN_SEL_BIT          16
`define STAMP_SEL_BIT        8
`define RSV_HI_MSB           19
`define RSV_HI_LSB           17
`define RSV_MID_MSB          11
`define RSV_MID_LSB          9
`define TRIG_SEL_MSB         1
`define TRIG_SEL_LSB         0
`define TRIG_SEL_RESERVED    2'h3

// trigger status register fields
`define TRIG_ERR_MSB         18
`define TRIG_ERR_LSB         16
`define TRIG_DONE_MSB        2
`define TRIG_DONE_LSB        0

// config register: domain check enable
`define DOMAIN_CHECK_BIT     4

// interrupt status/mask layout
`define IRQ_DONE_MSB         2
`define IRQ_DONE_LSB         0
`define IRQ_ERR_MSB          5
`define IRQ_ERR_LSB          3
`define IRQ_DROP_BIT         6
`define IRQ_WIDTH            7

`endif

// File: verif/ptp_global_index_trigger_status_assertions.sv
`timescale 1ns/1ps
module ptp_global_index_trigger_status_assertions (
  input wire        CLK,
  input wire        RST,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [11:0] PADDR,
  input wire        MSG_VALID,
  input wire        MSG_CAPTURE,
  input wire        MSG_FORWARD,
  input wire        MSG_DROP,
  input wire        pin_select_bit,
  input wire        stamp_unit_select_bit,
  input wire [1:0]  trig_unit_select_field,
  input wire [2:0]  TRIG_UNIT_ONEHOT,
  input wire [1:0]  STAMP_UNIT_ONEHOT,
  input wire [1:0]  PIN_ONEHOT,
  input wire        WIN_ACCESS,
  input wire        IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_capture_forward_pair: assert property (MSG_CAPTURE == MSG_FORWARD)
    else $error("capture and forward differ");
  a_one_outcome: assert property (MSG_VALID |=> MSG_CAPTURE != MSG_DROP)
    else $error("message outcome wrong");
  a_no_stray_outcome: assert property (!MSG_VALID |=> !MSG_CAPTURE && !MSG_DROP)
    else $error("outcome without message");
  a_pin_decode: assert property (PIN_ONEHOT == {pin_select_bit, !pin_select_bit})
    else $error("pin decode wrong");
  a_stamp_decode: assert property (STAMP_UNIT_ONEHOT == {stamp_unit_select_bit,
    !stamp_unit_select_bit}) else $error("stamp decode wrong");
  a_trig_decode: assert property (TRIG_UNIT_ONEHOT == ((trig_unit_select_field == 2'h3) ?
    3'h0 : 3'h1 << trig_unit_select_field)) else $error("trigger decode wrong");
  a_window_decode: assert property (WIN_ACCESS == (PSEL && PADDR >= 12'h52C &&
    PADDR <= 12'h5B3)) else $error("window decode wrong");
  a_index_write_only: assert property (!$stable({pin_select_bit, stamp_unit_select_bit,
    trig_unit_select_field}) |-> $past(PSEL && PENABLE && PWRITE && PADDR == 12'h520)
    || $past(RST)) else $error("index changed without write");
  cover property (MSG_VALID ##1 MSG_DROP);
  cover property (MSG_CAPTURE);
  cover property (IRQ);
endmodule
bind ptp_global_index_trigger_status ptp_global_index_trigger_status_assertions chk_u (.*);

// File: verif/ptp_global_index_trigger_status_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module ptp_global_index_trigger_status_test;
  reg          CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, MSG_VALID = 0;
  reg  [11:0]  PADDR = 0;
  reg  [31:0]  PWDATA = 0;
  reg  [3:0]   MSG_VERSION = 0;
  reg  [7:0]   MSG_DOMAIN = 0;
  reg  [2:0]   TRIG_LATE = 0, TRIG_DONE_EV = 0, trig_irq_request_enable = 0, TRIG_EN_CLEAR = 0;
  wire         PREADY, PSLVERR, MSG_CAPTURE, MSG_FORWARD, MSG_DROP, WIN_ACCESS, IRQ;
  wire         pin_select_bit, stamp_unit_select_bit;
  wire [1:0]   trig_unit_select_field, STAMP_UNIT_ONEHOT, PIN_ONEHOT;
  wire [2:0]   TRIG_UNIT_ONEHOT;
  wire [31:0]  PRDATA;
  wire [2:0]   outc = {MSG_CAPTURE, MSG_FORWARD, MSG_DROP};
  int          bad_count = 0, n_tests = 0;
  integer      seed = 32'h857b;
  logic [31:0] rq[$], ex_r;
  logic [2:0]  mq[$], ex_m;
  ptp_global_index_trigger_status dut_u (.*);
  always #20 CLK = ~CLK;
  task automatic conclude;
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bus(input [11:0] a, input w, input [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rd(input [11:0] a, input [31:0] e);
    rq.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic msg(input [3:0] v, input [7:0] d, input [2:0] e);
    mq.push_back(e);
    @(posedge CLK);
    MSG_VALID <= 1'b1;
    MSG_VERSION <= v;
    MSG_DOMAIN <= d;
    @(posedge CLK);
    MSG_VALID <= 1'b0;
  endtask
  task automatic pulse(input [2:0] late, input [2:0] done, input [2:0] clr);
    @(posedge CLK);
    TRIG_LATE <= late;
    TRIG_DONE_EV <= done;
    TRIG_EN_CLEAR <= clr;
    @(posedge CLK);
    TRIG_LATE <= 3'h0;
    TRIG_DONE_EV <= 3'h0;
    TRIG_EN_CLEAR <= 3'h0;
    #1;
  endtask
  always @(posedge CLK) begin
    if (PSEL && PENABLE && !PWRITE && PREADY) begin
      ex_r = rq.pop_front();
      `CHK(PRDATA, ex_r)
    end
    if (PSEL && PENABLE && PREADY) begin
      `CHK(PSLVERR, 1'b0)
    end
    if (outc != 3'h0) begin
      ex_m = mq.pop_front();
      `CHK(outc, ex_m)
    end
  end
  initial begin
    repeat (5000) @(posedge CLK);
    bad_count++;
    conclude;
  end
  initial begin
    logic [3:0]  v;
    logic [7:0]  d;
    logic [31:0] w;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    rd(12'h518, 32'h0000_0200);
    rd(12'h520, 32'h0);
    rd(12'h524, 32'h0);
    rd(12'h600, 32'h0);
    wr_ver: bus(12'h518, 1'b1, 32'hFFFF_F5A7);
    rd(12'h518, 32'h0000_05A7);
    for (int i = 0; i < 24; i++) begin
      if (i == 12) bus(12'h548, 1'b1, 32'h10);
      v = i[0] ? 4'h5 : 4'($random(seed));
      d = i[1] ? 8'hA7 : 8'($random(seed));
      msg(v, d, (v == 4'h5 && (i < 12 || d == 8'hA7)) ? 3'h6 : 3'h1);
    end
    for (int i = 0; i < 6; i++) begin
      w = $random(seed);
      if (w[1:0] == 2'h3) w[1:0] = 2'h2;
      bus(12'h520, 1'b1, w);
      rd(12'h520, w & 32'h000F_0F03);
    end
    bus(12'h544, 1'b1, 32'h7);
    trig_irq_request_enable <= 3'b101;
    pulse(3'b111, 3'b111, 3'b000);
    `CHK(IRQ, 1'b1)
    rd(12'h524, 32'h0005_0005);
    bus(12'h524, 1'b1, 32'h0007_0005);
    rd(12'h524, 32'h0005_0000);
    pulse(3'b000, 3'b000, 3'b001);
    rd(12'h524, 32'h0004_0000);
    bus(12'h540, 1'b1, 32'h7F);
    rd(12'h540, 32'h0);
    #1;
    `CHK(IRQ, 1'b0)
    pulse(3'b001, 3'b000, 3'b000);
    `CHK(IRQ, 1'b0)
    bus(12'h544, 1'b1, 32'h8);
    #1;
    `CHK(IRQ, 1'b1)
    repeat (2) @(posedge CLK);
    conclude;
  end
endmodule
